// ### sfpa_alu.sv
// Saturating fixed-point ALU for a speech codec datapath: short and long
// arithmetic, scaled multiplies, divide, shifts, widening and masking.
// Assumes the sequencing logic drives all operands synchronously to sys_clk_i
// and issues at most one operation per clock.
`timescale 1ns/1ps
module sfpa_alu import sfpa_pkg::*; (
   input wire logic sys_clk_i,                  // 20 MHz system clock
   input wire logic rst_n_i,                    // Asynchronous reset, active low
   input wire logic valid_i,                    // Operation strobe
   input wire sfpa_op_t op_i,                   // Operation select
   input wire logic [SFPA_SW-1:0] s_a_i,        // Short operand one
   input wire logic [SFPA_SW-1:0] s_b_i,        // Short operand two or constant
   input wire logic [SFPA_LW-1:0] l_a_i,        // Long operand one
   input wire logic [SFPA_LW-1:0] l_b_i,        // Long operand two
   input wire logic [SFPA_CW-1:0] cnt_i,        // Signed shift count
   input wire logic [2:0] pbits_i,              // Valid parameter bits, 2..7
   output logic res_valid_o,                    // Result valid
   output logic [SFPA_SW-1:0] s_res_o,          // Short result
   output logic [SFPA_LW-1:0] l_res_o,          // Long result
   output logic sat_o                           // Result was clamped
);

   // ***********************************************************
   // State
   // ***********************************************************
   sfpa_state_t state_q;
   sfpa_state_t state_d;

   // ***********************************************************
   // Shift helper shared by short and long shifts
   // ***********************************************************
   // Short words are shifted as sign-extended longs and cut back, so one
   // shifter covers both widths; counts beyond the word clamp cleanly.
   function automatic logic [31:0] sfpa_shift(input logic [31:0] v,
                                              input logic [15:0] cnt,
                                              input logic left);
      logic go_left;
      logic [16:0] mag;
      logic [31:0] r;
      go_left = left ^ cnt[15];
      if (cnt[15]) begin
         mag = 17'h00000 - {cnt[15], cnt};
      end else begin
         mag = {1'b0, cnt};
      end
      if (go_left) begin
         if (mag >= SFPA_SHL_LIM) begin
            r = 32'h00000000; // All bits shifted out
         end else begin
            r = v << mag[4:0];
         end
      end else begin
         if (mag >= SFPA_SHR_LIM) begin
            r = {32{v[31]}}; // Only sign copies remain
         end else begin
            r = 32'($signed(v) >>> mag[4:0]);
         end
      end
      return r;
   endfunction

   // ***********************************************************
   // Operand widening
   // ***********************************************************
   logic [SFPA_LW-1:0] a_wide;
   logic [SFPA_LW-1:0] b_wide;

   // Short operands enter long arithmetic only after sign extension
   assign a_wide = {{(SFPA_LW-SFPA_SW){s_a_i[SFPA_SW-1]}}, s_a_i};
   assign b_wide = {{(SFPA_LW-SFPA_SW){s_b_i[SFPA_SW-1]}}, s_b_i};

   // Short shifts run on the widened operand; the low half is kept
   logic [SFPA_LW-1:0] sh_left;
   logic [SFPA_LW-1:0] sh_right;
   assign sh_left = sfpa_shift(a_wide, cnt_i, 1'b1);
   assign sh_right = sfpa_shift(a_wide, cnt_i, 1'b0);

   // ***********************************************************
   // Short saturating add and subtract
   // ***********************************************************
   logic [SFPA_SW-1:0] s_sum;
   logic s_sum_sat;
   logic s_sub;

   assign s_sub = (op_i == SFPA_OP_SUB);

   sfpa_sat_add #(
      .W(SFPA_SW)
   ) u_short_add (
      .a_i(s_a_i),
      .b_i(s_b_i),
      .sub_i(s_sub),
      .sum_o(s_sum),
      .sat_o(s_sum_sat)
   );

   // ***********************************************************
   // Long saturating add and subtract
   // ***********************************************************
   logic [SFPA_LW-1:0] l_b_sel;
   logic [SFPA_LW-1:0] l_sum;
   logic l_sum_sat;
   logic l_sub;
   logic l_konst;

   // Constant forms take the second operand from the short port
   assign l_konst = (op_i == SFPA_OP_L_ADD_K) || (op_i == SFPA_OP_L_SUB_K);
   assign l_sub = (op_i == SFPA_OP_L_SUB) || (op_i == SFPA_OP_L_SUB_K);
   assign l_b_sel = l_konst ? b_wide : l_b_i;

   sfpa_sat_add #(
      .W(SFPA_LW)
   ) u_long_add (
      .a_i(l_a_i),
      .b_i(l_b_sel),
      .sub_i(l_sub),
      .sum_o(l_sum),
      .sat_o(l_sum_sat)
   );

   // ***********************************************************
   // Products
   // ***********************************************************
   logic [SFPA_LW-1:0] prod;
   logic [SFPA_LW:0] prod_rnd;
   logic both_min;
   logic [SFPA_SW-1:0] mult_res;
   logic [SFPA_SW-1:0] mult_r_res;
   logic [SFPA_LW-1:0] l_mult_res;

   // Full signed 32-bit product of two shorts
   // Operands are widened first; a cast of the product would keep 16 bits
   assign prod = 32'($signed(s_a_i)) * 32'($signed(s_b_i));
   assign both_min = (s_a_i == SFPA_S_MIN) && (s_b_i == SFPA_S_MIN);
   // Guard bit keeps the rounding add from wrapping
   assign prod_rnd = {prod[SFPA_LW-1], prod} + SFPA_ROUND;

   // Min times min is the only product that leaves the short range
   assign mult_res = both_min ? SFPA_S_MAX :
                     prod[SFPA_FRAC_SHIFT +: SFPA_SW];
   assign mult_r_res = both_min ? SFPA_S_MAX :
                       prod_rnd[SFPA_FRAC_SHIFT +: SFPA_SW];
   // No clamp: the requester never offers min times min here
   assign l_mult_res = {prod[SFPA_LW-2:0], 1'b0};

   // ***********************************************************
   // Magnitude
   // ***********************************************************
   logic [SFPA_SW-1:0] abs_res;
   logic [SFPA_SW-1:0] s_a_neg;

   assign s_a_neg = SFPA_SW'(0) - s_a_i;
   // Negating the most negative short would wrap back onto itself
   assign abs_res = (s_a_i == SFPA_S_MIN) ? SFPA_S_MAX :
                    (s_a_i[SFPA_SW-1] ? s_a_neg : s_a_i);

   // ***********************************************************
   // Fractional divide
   // ***********************************************************
   logic [SFPA_SW-1:0] div_res;

   // Unrolled for single-cycle issue; deepest path of the block
   sfpa_frac_div #(
      .W(SFPA_SW)
   ) u_div (
      .num_i(s_a_i),
      .den_i(s_b_i),
      .quo_o(div_res)
   );

   // ***********************************************************
   // Valid-bit masking of received words
   // ***********************************************************
   logic [2:0] pbits_c;
   logic [SFPA_SW-1:0] par_mask;
   logic [SFPA_SW-1:0] smp_res;
   logic [SFPA_SW-1:0] par_res;

   // Out-of-range widths are pulled into the legal span
   always_comb begin
      if (pbits_i < SFPA_PBITS_MIN) begin
         pbits_c = SFPA_PBITS_MIN;
      end else begin
         pbits_c = pbits_i;
      end
      par_mask = SFPA_SW'(~(SFPA_LW'(-1) << pbits_c));
   end

   // Junk in the low sample bits or high parameter bits is dropped
   assign smp_res = s_a_i & SFPA_SAMPLE_MASK;
   assign par_res = s_a_i & par_mask;

   // ***********************************************************
   // Result select
   // ***********************************************************
   // Short results are held sign-extended so the long port is meaningful
   always_comb begin
      state_d = state_q;
      state_d.valid = valid_i;
      if (valid_i) begin
         state_d.sat = 1'b0;
         unique case (op_i)
            SFPA_OP_ADD,
            SFPA_OP_SUB: begin
               state_d.res = 32'($signed(s_sum));
               state_d.sat = s_sum_sat;
            end
            SFPA_OP_MULT: begin
               state_d.res = 32'($signed(mult_res));
               state_d.sat = both_min;
            end
            SFPA_OP_MULT_R: begin
               state_d.res = 32'($signed(mult_r_res));
               state_d.sat = both_min;
            end
            SFPA_OP_ABS: begin
               state_d.res = 32'($signed(abs_res));
               state_d.sat = (s_a_i == SFPA_S_MIN);
            end
            SFPA_OP_DIV: begin
               state_d.res = {{(SFPA_LW-SFPA_SW){1'b0}}, div_res};
            end
            SFPA_OP_L_MULT: begin
               state_d.res = l_mult_res;
            end
            SFPA_OP_L_ADD,
            SFPA_OP_L_SUB,
            SFPA_OP_L_ADD_K,
            SFPA_OP_L_SUB_K: begin
               state_d.res = l_sum;
               state_d.sat = l_sum_sat;
            end
            SFPA_OP_SHL: begin
               state_d.res = 32'($signed(sh_left[SFPA_SW-1:0]));
            end
            SFPA_OP_SHR: begin
               state_d.res = 32'($signed(sh_right[SFPA_SW-1:0]));
            end
            SFPA_OP_L_SHL: begin
               state_d.res = sfpa_shift(l_a_i, cnt_i, 1'b1);
            end
            SFPA_OP_L_SHR: begin
               state_d.res = sfpa_shift(l_a_i, cnt_i, 1'b0);
            end
            SFPA_OP_WIDEN: begin
               state_d.res = a_wide;
            end
            SFPA_OP_NARROW: begin
               // Plain truncation, never clamped
               state_d.res = 32'($signed(l_a_i[SFPA_SW-1:0]));
            end
            SFPA_OP_MASK_SMP: begin
               state_d.res = 32'($signed(smp_res));
            end
            SFPA_OP_MASK_PAR: begin
               state_d.res = {{(SFPA_LW-SFPA_SW){1'b0}}, par_res};
            end
            default: begin
               // Unused codes return zero rather than stale data
               state_d.res = 32'h00000000;
            end
         endcase
      end
   end

   // ***********************************************************
   // State register
   // ***********************************************************
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= SFPA_STATE_RST;
      end else begin
         state_q <= state_d;
      end
   end

   // ***********************************************************
   // Outputs
   // ***********************************************************
   // Results are held between operations; valid marks only fresh ones
   assign res_valid_o = state_q.valid;
   assign l_res_o = state_q.res;
   assign s_res_o = state_q.res[SFPA_SW-1:0];
   assign sat_o = state_q.sat;

endmodule

// ### sfpa_pkg.sv
// Shared constants, operation codes and state layout of the fixed-point ALU.
// Assumes every design file imports the whole package in its module header.
package sfpa_pkg;

   // ***********************************************************
   // Word types and limits
   // ***********************************************************
   localparam int SFPA_SW = 16; // Short word width
   localparam int SFPA_LW = 32; // Long word width
   localparam int SFPA_CW = 16; // Shift count width

   localparam logic [15:0] SFPA_S_MAX = 16'h7fff; // +32767
   localparam logic [15:0] SFPA_S_MIN = 16'h8000; // -32768
   localparam logic [31:0] SFPA_L_MAX = 32'h7fffffff;
   localparam logic [31:0] SFPA_L_MIN = 32'h80000000;

   // ***********************************************************
   // Multiply scaling
   // ***********************************************************
   localparam logic [32:0] SFPA_ROUND = 33'h000004000; // 16384 rounding term
   localparam int SFPA_FRAC_SHIFT = 15;

   // ***********************************************************
   // Shift count limits
   // ***********************************************************
   localparam logic [16:0] SFPA_SHL_LIM = 17'h00020; // At or above: all bits gone
   localparam logic [16:0] SFPA_SHR_LIM = 17'h0001f; // At or above: sign only

   // ***********************************************************
   // Valid-bit masks of received words
   // ***********************************************************
   localparam logic [15:0] SFPA_SAMPLE_MASK = 16'hfff8; // Top 13 bits valid
   localparam logic [2:0] SFPA_PBITS_MIN = 3'h2; // Fewest valid parameter bits
   localparam logic [2:0] SFPA_PBITS_MAX = 3'h7; // Most valid parameter bits

   // ***********************************************************
   // Operation codes
   // ***********************************************************
   typedef enum logic [4:0] {
      SFPA_OP_ADD,      // Short saturating add
      SFPA_OP_SUB,      // Short saturating subtract
      SFPA_OP_MULT,     // Fractional product
      SFPA_OP_MULT_R,   // Rounded fractional product
      SFPA_OP_ABS,      // Saturating magnitude
      SFPA_OP_DIV,      // Fractional quotient
      SFPA_OP_L_MULT,   // Widening doubled product
      SFPA_OP_L_ADD,    // Long saturating add
      SFPA_OP_L_SUB,    // Long saturating subtract
      SFPA_OP_L_ADD_K,  // Long add of a short constant
      SFPA_OP_L_SUB_K,  // Long subtract of a short constant
      SFPA_OP_SHL,      // Short left shift
      SFPA_OP_SHR,      // Short right shift
      SFPA_OP_L_SHL,    // Long left shift
      SFPA_OP_L_SHR,    // Long right shift
      SFPA_OP_WIDEN,    // Short to long
      SFPA_OP_NARROW,   // Long to short
      SFPA_OP_MASK_SMP, // Keep valid sample bits
      SFPA_OP_MASK_PAR  // Keep valid parameter bits
   } sfpa_op_t;

   // ***********************************************************
   // Registered state of the top module
   // ***********************************************************
   typedef struct packed {
      logic valid;
      logic sat;
      logic [31:0] res;
   } sfpa_state_t;

   localparam sfpa_state_t SFPA_STATE_RST = '{valid: 1'b0, sat: 1'b0, res: 32'h00000000};

endpackage

// ### sfpa_sat_add.sv
// Saturating two's complement adder and subtractor of parameterised width.
// Assumes operands of equal width; purely combinational.
`timescale 1ns/1ps
module sfpa_sat_add import sfpa_pkg::*; #(
   parameter int W = 16
) (
   input wire logic [W-1:0] a_i,  // First operand
   input wire logic [W-1:0] b_i,  // Second operand
   input wire logic sub_i,        // High: a minus b
   output logic [W-1:0] sum_o,    // Clamped result
   output logic sat_o             // Result was clamped
);

   // ***********************************************************
   // One guard bit catches overflow in either direction
   // ***********************************************************
   logic [W:0] wide;

   always_comb begin
      if (sub_i) begin
         wide = {a_i[W-1], a_i} - {b_i[W-1], b_i};
      end else begin
         wide = {a_i[W-1], a_i} + {b_i[W-1], b_i};
      end
      sat_o = wide[W] ^ wide[W-1];
      if (!sat_o) begin
         sum_o = wide[W-1:0];
      end else if (wide[W]) begin
         sum_o = {1'b1, {(W-1){1'b0}}}; // Below range: most negative
      end else begin
         sum_o = {1'b0, {(W-1){1'b1}}}; // Above range: most positive
      end
   end

endmodule

// ### sfpa_frac_div.sv
// Fractional restoring divider, fully unrolled within one clock.
// Assumes 0 <= num <= den and den > 0; other operands give no defined answer.
`timescale 1ns/1ps
module sfpa_frac_div import sfpa_pkg::*; #(
   parameter int W = 16
) (
   input wire logic [W-1:0] num_i, // Dividend
   input wire logic [W-1:0] den_i, // Divisor
   output logic [W-1:0] quo_o      // Quotient, top bit zero
);

   // ***********************************************************
   // W-1 quotient bits; equal operands fill every bit, giving max
   // ***********************************************************
   logic [W:0] rem;
   logic [W:0] den_x;

   always_comb begin
      rem = {1'b0, num_i};
      den_x = {1'b0, den_i};
      quo_o = '0;
      for (int k = 0; k < W - 1; k++) begin
         quo_o = {quo_o[W-2:0], 1'b0};
         rem = {rem[W-1:0], 1'b0};
         if (rem >= den_x) begin
            rem = rem - den_x;
            quo_o[0] = 1'b1;
         end
      end
   end

endmodule

// ### sfpa_alu_chk.sv
// Concurrent checks on the ports of the fixed-point ALU.
// Assumes binding into sfpa_alu; sees only its ports.
`timescale 1ns/1ps
module sfpa_alu_chk import sfpa_pkg::*; (
   input wire logic sys_clk_i, // Clock
   input wire logic rst_n_i, // Reset, active low
   input wire logic valid_i, // Strobe
   input wire sfpa_op_t op_i, // Select
   input wire logic [SFPA_SW-1:0] s_a_i, // Short one
   input wire logic [SFPA_SW-1:0] s_b_i, // Short two
   input wire logic [SFPA_LW-1:0] l_a_i, // Long one
   input wire logic [SFPA_LW-1:0] l_b_i, // Long two
   input wire logic [SFPA_CW-1:0] cnt_i, // Count
   input wire logic [2:0] pbits_i, // Parameter bits
   input wire logic res_valid_o, // Result strobe
   input wire logic [SFPA_SW-1:0] s_res_o, // Short result
   input wire logic [SFPA_LW-1:0] l_res_o, // Long result
   input wire logic sat_o // Clamped
);
   // ***********************************************************
   // Reference values
   // ***********************************************************
   logic [16:0] add17, sub17;
   logic [32:0] ladd33;
   logic [15:0] add_x, sub_x;
   logic [31:0] ladd_x, shl_x, shr_x;
   logic add_ov, sub_ov, take;
   // Overflow: top two bits differ
   assign add17 = {s_a_i[15], s_a_i} + {s_b_i[15], s_b_i};
   assign sub17 = {s_a_i[15], s_a_i} - {s_b_i[15], s_b_i};
   assign ladd33 = {l_a_i[31], l_a_i} + {l_b_i[31], l_b_i};
   assign add_ov = add17[16] ^ add17[15];
   assign sub_ov = sub17[16] ^ sub17[15];
   assign add_x = add_ov ? (add17[16] ? SFPA_S_MIN : SFPA_S_MAX) : add17[15:0];
   assign sub_x = sub_ov ? (sub17[16] ? SFPA_S_MIN : SFPA_S_MAX) : sub17[15:0];
   assign ladd_x = (ladd33[32] ^ ladd33[31]) ? (ladd33[32] ? SFPA_L_MIN : SFPA_L_MAX)
      : ladd33[31:0];
   assign shl_x = l_a_i << cnt_i[4:0];
   assign shr_x = $signed(l_a_i) >>> cnt_i[4:0];
   // No result for a request in reset
   assign take = valid_i && rst_n_i;

   // ***********************************************************
   // Assertions
   // ***********************************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   lat_one_a: assert property (res_valid_o == $past(take))
      else $error("late strobe");
   hold_idle_a: assert property (!valid_i |=> $stable(s_res_o) && $stable(l_res_o))
      else $error("results moved");
   add_clamp_a: assert property (valid_i && op_i == SFPA_OP_ADD |=>
      s_res_o == $past(add_x) && sat_o == $past(add_ov)) else $error("short add");
   sub_clamp_a: assert property (valid_i && op_i == SFPA_OP_SUB |=>
      s_res_o == $past(sub_x) && sat_o == $past(sub_ov)) else $error("short sub");
   ladd_clamp_a: assert property (valid_i && op_i == SFPA_OP_L_ADD |=>
      l_res_o == $past(ladd_x)) else $error("long add");
   min_mult_a: assert property (valid_i && (op_i == SFPA_OP_MULT || op_i == SFPA_OP_MULT_R)
      && s_a_i == SFPA_S_MIN && s_b_i == SFPA_S_MIN |=> s_res_o == SFPA_S_MAX && sat_o)
      else $error("min product");
   abs_min_a: assert property (valid_i && op_i == SFPA_OP_ABS && s_a_i == SFPA_S_MIN |=>
      l_res_o == 32'h00007fff) else $error("abs min");
   div_top_a: assert property (valid_i && op_i == SFPA_OP_DIV |=> !s_res_o[15])
      else $error("quotient negative");
   div_eq_a: assert property (valid_i && op_i == SFPA_OP_DIV && s_a_i == s_b_i
      && s_b_i != 16'h0000 && !s_b_i[15] |=> s_res_o == SFPA_S_MAX) else $error("equal divide");
   widen_ext_a: assert property (valid_i && op_i == SFPA_OP_WIDEN |=>
      s_res_o == $past(s_a_i) && l_res_o == {{16{s_res_o[15]}}, s_res_o}) else $error("widen");
   narrow_low_a: assert property (valid_i && op_i == SFPA_OP_NARROW |=>
      s_res_o == $past(l_a_i[15:0]) && !sat_o) else $error("narrow");
   shl_fill_a: assert property (valid_i && op_i == SFPA_OP_L_SHL && cnt_i < 16'h0020 |=>
      l_res_o == $past(shl_x)) else $error("long shl");
   shr_sign_a: assert property (valid_i && op_i == SFPA_OP_L_SHR && cnt_i < 16'h0020 |=>
      l_res_o == $past(shr_x)) else $error("long shr");
   mask_smp_a: assert property (valid_i && op_i == SFPA_OP_MASK_SMP |=>
      s_res_o[2:0] == 3'h0 && s_res_o[15:3] == $past(s_a_i[15:3])) else $error("mask");
endmodule

// ### sfpa_seq_model.sv
// Behavioural sequencer that presents operations to the ALU.
// Assumes the request changes just after a rising edge.
`timescale 1ns/1ps
module sfpa_seq_model import sfpa_pkg::*; (
   input wire logic sys_clk_i, // Clock
   input wire logic clean_i, // Zero non-valid sample bits and parameter bits 15:7
   input wire logic [120:0] rq_i, // Valid, op and operands
   output logic valid_o, // Strobe
   output sfpa_op_t op_o, // Select
   output logic [15:0] s_a_o, // Short one
   output logic [15:0] s_b_o, // Short two
   output logic [31:0] l_a_o, // Long one
   output logic [31:0] l_b_o, // Long two
   output logic [15:0] cnt_o, // Count
   output logic [2:0] pbits_o // Parameter bits
);
   logic v;
   logic [4:0] op;
   logic [15:0] a, b, c;
   logic [31:0] la, lb;
   logic [2:0] pb;
   initial {valid_o, op_o, s_a_o, s_b_o, l_a_o, l_b_o, cnt_o, pbits_o} = '0;
   // Driven on the falling edge; idle slots carry noise
   always @(negedge sys_clk_i) begin
      {v, op, a, b, la, lb, c, pb} = rq_i;
      if (op == SFPA_OP_L_MULT && a == 16'h8000 && b == 16'h8000) b = 16'h7fff;
      // Legal divide: 0 <= num <= den, den > 0
      if (op == SFPA_OP_DIV) begin
         a[15] = 1'b0;
         b[15] = 1'b0;
         if (b < a) {a, b} = {b, a};
         if (b == 16'h0000) b = 16'h0001;
      end
      if (clean_i && op == SFPA_OP_MASK_SMP) a[2:0] = 3'h0;
      if (clean_i && op == SFPA_OP_MASK_PAR) a[15:7] = 9'h000;
      {valid_o, s_a_o, s_b_o, l_a_o, l_b_o, cnt_o, pbits_o} <= {v, a, b, la, lb, c, pb};
      op_o <= sfpa_op_t'(op);
   end
endmodule

// ### tb_saturating_fixed_point_alu.sv
// Self-checking bench of the fixed-point ALU against an integer model.
// Assumes the sequencer model and checker compile first.
`timescale 1ns/1ps
bind sfpa_alu sfpa_alu_chk chk (.sys_clk_i, .rst_n_i, .valid_i, .op_i, .s_a_i, .s_b_i,
   .l_a_i, .l_b_i, .cnt_i, .pbits_i, .res_valid_o, .s_res_o, .l_res_o, .sat_o);
module tb_saturating_fixed_point_alu import sfpa_pkg::*;;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic clean = 1'b0;
   logic valid_i, res_valid_o, sat_o, vq;
   sfpa_op_t op_i;
   logic [15:0] s_a_i, s_b_i, cnt_i, s_res_o, a;
   logic [31:0] l_a_i, l_b_i, l_res_o;
   logic [2:0] pbits_i;
   logic [120:0] rq = '0;
   logic [48:0] exp_q;
   logic [15:0] cnts [8] = '{16'h0, 16'h1, 16'hf, 16'h1f, 16'h20, 16'hfff1, 16'hffe0, 16'hffe1};
   int fails = 0;
   int compares = 0;
   int cyc = 0;

   sfpa_alu uut (.sys_clk_i, .rst_n_i, .valid_i, .op_i, .s_a_i, .s_b_i, .l_a_i, .l_b_i,
      .cnt_i, .pbits_i, .res_valid_o, .s_res_o, .l_res_o, .sat_o);
   sfpa_seq_model seq (.sys_clk_i, .clean_i(clean), .rq_i(rq), .valid_o(valid_i),
      .op_o(op_i), .s_a_o(s_a_i), .s_b_o(s_b_i), .l_a_o(l_a_i), .l_b_o(l_b_i),
      .cnt_o(cnt_i), .pbits_o(pbits_i));

   // ***********************************************************
   // Clock, model and comparison
   // ***********************************************************
   initial forever #25 sys_clk_i = ~sys_clk_i;

   // Model: {sat, long, short}
   function automatic logic [48:0] ref_f(logic [4:0] op, logic [15:0] a, b,
      logic [31:0] la, lb, logic [15:0] c, logic [2:0] pb);
      longint x, y, r;
      int n, m;
      logic s, lg;
      x = $signed(a);
      y = $signed(b);
      n = $signed(c);
      m = n < 0 ? -n : n;
      r = 0;
      s = 1'b0;
      lg = op > 5'd5 && op < 5'd11 || op == 5'd13 || op == 5'd14;
      if (op > 5'd6 && op < 5'd9) y = $signed(lb);
      if (lg && op != 5'd6) x = $signed(la);
      case (op)
         0: r = x + y;
         1: r = x - y;
         2, 3: r = (x * y + (op == 5'd3 ? 16384 : 0)) >>> 15;
         4: r = x < 0 ? -x : x;
         5: r = a == b ? 32767 : (x << 15) / y;
         6: r = (x * y) << 1;
         7, 8, 9, 10: r = op[0] ? x + y : x - y;
         11, 12, 13, 14:
            if ((op == 5'd11 || op == 5'd13) ^ (n < 0)) r = m > 31 ? 0 : x << m;
            else r = x >>> (m > 31 ? 31 : m);
         15: r = x;
         16: r = $signed(la[15:0]);
         17: r = x & -8;
         18: r = a & ((1 << (pb < 3'h2 ? 2 : pb)) - 1);
         default: r = 0;
      endcase
      if ((op == 5'd2 || op == 5'd3) && a == 16'h8000 && b == 16'h8000 || op == 4 && r == 32768)
      begin
         r = 32767;
         s = 1'b1;
      end
      if (op < 5'd2 && (r > 32767 || r < -32768)) begin
         r = r > 0 ? 32767 : -32768;
         s = 1'b1;
      end
      if (op > 5'd6 && op < 5'd11 && (r > 64'sh7fffffff || r < -64'sh80000000)) begin
         r = r > 0 ? 64'sh7fffffff : -64'sh80000000;
         s = 1'b1;
      end
      if (!lg) r = $signed(r[15:0]);
      return {s, r[31:0], r[15:0]};
   endfunction

   // Expected results, held like the outputs
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         vq <= 1'b0;
         exp_q <= '0;
      end else begin
         vq <= valid_i;
         if (valid_i) exp_q <= ref_f(op_i, s_a_i, s_b_i, l_a_i, l_b_i, cnt_i, pbits_i);
      end
   end

   task automatic check(logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Sample settled outputs on the falling edge
   always @(negedge sys_clk_i) begin
      check(res_valid_o, vq);
      check(s_res_o, exp_q[15:0]);
      check(l_res_o, exp_q[47:16]);
      check(sat_o, exp_q[48]);
   end

   task automatic complete_run();
      $display("Counts: compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Hang guard, far beyond the 3.4k cycles needed
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         complete_run();
      end
   end

   // ***********************************************************
   // Stimulus
   // ***********************************************************
   task automatic issue(logic [4:0] op, logic [15:0] a, b, logic [31:0] la, lb,
      logic [15:0] c, logic [2:0] pb);
      rq = {1'b1, op, a, b, la, lb, c, pb};
      @(posedge sys_clk_i);
   endtask
   task automatic s2(logic [4:0] op, logic [15:0] a, b);
      issue(op, a, b, 32'h0, 32'h0, 16'h0, 3'h0);
   endtask
   task automatic l2(logic [4:0] op, logic [31:0] la, lb, logic [15:0] b);
      issue(op, 16'h0, b, la, lb, 16'h0, 3'h0);
   endtask
   task automatic rnd(int k);
      for (int i = 0; i < k; i++) begin
         a = $urandom % 8 == 0 ? 16'h8000 : 16'($urandom);
         clean = i[0];
         if ($urandom % 4 == 0)
            rq = {1'b0, 120'({$urandom, $urandom, $urandom, $urandom})};
         else
            rq = {1'b1, 5'($urandom % 19), a, $urandom % 4 == 0 ? a : 16'($urandom),
               32'($urandom), 32'($urandom), $urandom % 2 ? 16'($urandom % 80 - 40)
               : 16'($urandom), 3'($urandom)};
         @(posedge sys_clk_i);
      end
   endtask

   initial begin
      void'($urandom(3));
      repeat (12) @(negedge sys_clk_i);
      rst_n_i = 1'b1;
      @(posedge sys_clk_i);
      // Boundary cases, back to back
      s2(SFPA_OP_ADD, 16'h7fff, 16'h0001);
      s2(SFPA_OP_ADD, 16'h8000, 16'hffff);
      s2(SFPA_OP_SUB, 16'h8000, 16'h0001);
      s2(SFPA_OP_SUB, 16'h7fff, 16'hffff);
      s2(SFPA_OP_MULT, 16'h8000, 16'h8000);
      s2(SFPA_OP_MULT, 16'h0001, 16'h4000);
      s2(SFPA_OP_MULT_R, 16'h8000, 16'h8000);
      s2(SFPA_OP_MULT_R, 16'h0001, 16'h4000);
      s2(SFPA_OP_ABS, 16'h8000, 16'h0000);
      s2(SFPA_OP_DIV, 16'h1234, 16'h1234);
      s2(SFPA_OP_DIV, 16'h0001, 16'h7fff);
      s2(SFPA_OP_L_MULT, 16'h8000, 16'h7fff);
      l2(SFPA_OP_L_ADD, 32'h7fffffff, 32'h00000001, 16'h0);
      l2(SFPA_OP_L_SUB, 32'h80000000, 32'h00000001, 16'h0);
      l2(SFPA_OP_L_ADD_K, 32'h7fffffff, 32'h0, 16'hffff);
      l2(SFPA_OP_L_SUB_K, 32'h80000000, 32'h0, 16'hffff);
      l2(SFPA_OP_NARROW, 32'h8765c321, 32'h0, 16'h0);
      s2(SFPA_OP_WIDEN, 16'h8001, 16'h0);
      s2(SFPA_OP_MASK_SMP, 16'hffff, 16'h0);
      // Shift edge counts, all parameter widths
      foreach (cnts[j])
         for (int op = 11; op < 15; op++)
            issue(5'(op), 16'h8421, 16'h0, 32'h87654321, 32'h0, cnts[j], 3'h0);
      for (int p = 0; p < 8; p++) issue(SFPA_OP_MASK_PAR, 16'hffff, 16'h0, 32'h0, 32'h0, 16'h0,
         3'(p));
      $display("Test directed done");
      rnd(3000);
      $display("Test random done");
      // Reset with a request standing
      s2(SFPA_OP_ADD, 16'h7fff, 16'h7fff);
      @(negedge sys_clk_i);
      rst_n_i = 1'b0;
      repeat (3) @(negedge sys_clk_i);
      rst_n_i = 1'b1;
      @(posedge sys_clk_i);
      rnd(300);
      $display("Test reset done");
      complete_run();
   end
endmodule
